// *** core/cwg_pkg.sv ***
// Package with register map, field layouts, reset values and states of the waveform generator
package cwg_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on APB
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RIS = 8'h04;
  localparam logic [7:0] OFF_RSIM = 8'h08;
  localparam logic [7:0] OFF_FIS = 8'h0C;
  localparam logic [7:0] OFF_FSIM = 8'h10;
  localparam logic [7:0] OFF_DBR = 8'h14;
  localparam logic [7:0] OFF_DBF = 8'h18;
  localparam logic [7:0] OFF_BLKR = 8'h1C;
  localparam logic [7:0] OFF_BLKF = 8'h20;
  localparam logic [7:0] OFF_PHR = 8'h24;
  localparam logic [7:0] OFF_PHF = 8'h28;
  localparam logic [7:0] OFF_STEER = 8'h2C;
  localparam logic [7:0] OFF_STAT = 8'h30;

  // ----------------------------------------------------------------
  // Field encodings, widths and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_HB = 3'h4;
  localparam logic [2:0] MODE_PP = 3'h5;
  localparam logic [1:0] CS_OSC = 2'h0;
  localparam logic [1:0] CS_FOSC4 = 2'h1;
  localparam logic [1:0] CS_FOSC = 2'h2;
  localparam int SRC_N = 8;
  localparam int CNT_W = 6;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [3:0] STEER_RST = 4'hF;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [5:0] CNT_RST = 6'h00;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [5:0] CNT_ONE = 6'h01;

  // Control register layout: clock select above mode
  typedef struct packed {
    logic [1:0] cs;
    logic [2:0] mode;
  } cwg_ctrl_t;

  // Steering of primary to A/C and complementary to B/D
  typedef struct packed {
    logic to_d;
    logic to_c;
    logic to_b;
    logic to_a;
  } cwg_steer_t;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RPH = 5'h02,
    ST_RDB = 5'h04,
    ST_FPH = 5'h08,
    ST_FDB = 5'h10
  } cwg_state_t;

endpackage

// *** core/cwg_top.sv ***
// Complementary waveform generator with APB register file
`timescale 1ns/1ns

module cwg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic [7:0] rise_src,
  input wire logic [7:0] fall_src,
  output logic drive_out_a,
  output logic drive_out_b,
  output logic drive_out_c,
  output logic drive_out_d
);

  // ----------------------------------------------------------------
  // Registers and internal state
  // ----------------------------------------------------------------
  cwg_pkg::cwg_ctrl_t ctrl_r;
  cwg_pkg::cwg_steer_t steer_r;
  cwg_pkg::cwg_state_t state_r;
  logic [7:0] ris_r, rsim_r, fis_r, fsim_r;
  logic [5:0] dbr_r, dbf_r, blkr_r, blkf_r, phr_r, phf_r;
  logic [5:0] cnt_r, blank_rise_r, blank_fall_r;
  logic [7:0] rise_q_r, rise_p_r, fall_q_r, fall_p_r;
  logic rise_comb_r, fall_comb_r;
  logic [1:0] div_r;
  logic prim_r, comp_r, pair_r;
  logic ref_tick, active, acc, wr_en;
  logic [7:0] rise_sig, fall_sig;
  logic rise_comb, fall_comb, rise_ev, fall_ev;
  logic [31:0] rd_nxt;
  logic map_hit;

  assign active = (ctrl_r.mode == cwg_pkg::MODE_HB) || (ctrl_r.mode == cwg_pkg::MODE_PP);
  assign acc = psel && penable;
  assign wr_en = acc && pready && pwrite;

  // ----------------------------------------------------------------
  // Reference clock selection
  // ----------------------------------------------------------------
  // Free divider for the system clock over four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // Oscillator tick arrives as an enable; reserved select stops all timers
  always_comb begin
    case (ctrl_r.cs)
      cwg_pkg::CS_OSC: ref_tick = osc_tick;
      cwg_pkg::CS_FOSC4: ref_tick = (div_r == cwg_pkg::DIV4_LAST);
      cwg_pkg::CS_FOSC: ref_tick = 1'b1;
      default: ref_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Event input detection
  // ----------------------------------------------------------------
  // Resample on the reference tick so one edge gives one event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q_r <= cwg_pkg::SRC_RST;
      rise_p_r <= cwg_pkg::SRC_RST;
      fall_q_r <= cwg_pkg::SRC_RST;
      fall_p_r <= cwg_pkg::SRC_RST;
    end else if (ref_tick) begin
      rise_q_r <= rise_src;
      rise_p_r <= rise_q_r;
      fall_q_r <= fall_src;
      fall_p_r <= fall_q_r;
    end
  end

  // Falling sources are inverted so that the OR rises on their activity
  assign rise_sig = (rsim_r & rise_q_r & ~rise_p_r) | (~rsim_r & rise_q_r);
  assign fall_sig = (fsim_r & ~fall_q_r & fall_p_r) | (~fsim_r & ~fall_q_r);
  assign rise_comb = |(ris_r & rise_sig);
  assign fall_comb = |(fis_r & fall_sig);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_comb_r <= 1'b0;
      fall_comb_r <= 1'b0;
    end else if (ref_tick) begin
      rise_comb_r <= rise_comb;
      fall_comb_r <= fall_comb;
    end
  end

  // Blanked events are dropped, not held over
  assign rise_ev = active && ref_tick && rise_comb && !rise_comb_r
                   && (blank_rise_r == cwg_pkg::CNT_RST);
  assign fall_ev = active && ref_tick && fall_comb && !fall_comb_r
                   && (blank_fall_r == cwg_pkg::CNT_RST);

  // ----------------------------------------------------------------
  // Blanking counters
  // ----------------------------------------------------------------
  // Rise inputs are blanked after a fall drive, fall inputs after a rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_rise_r <= cwg_pkg::CNT_RST;
      blank_fall_r <= cwg_pkg::CNT_RST;
    end else begin
      if (fall_ev) begin
        blank_rise_r <= blkr_r;
      end else if (ref_tick && blank_rise_r != cwg_pkg::CNT_RST) begin
        blank_rise_r <= blank_rise_r - cwg_pkg::CNT_ONE;
      end
      if (rise_ev) begin
        blank_fall_r <= blkf_r;
      end else if (ref_tick && blank_fall_r != cwg_pkg::CNT_RST) begin
        blank_fall_r <= blank_fall_r - cwg_pkg::CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event sequencer: phase delay, then dead-band, then drive
  // ----------------------------------------------------------------
  // A falling event wins over a rising one in the same tick, ending drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= cwg_pkg::ST_IDLE;
      cnt_r <= cwg_pkg::CNT_RST;
      prim_r <= 1'b0;
      comp_r <= 1'b0;
    end else if (!active) begin
      state_r <= cwg_pkg::ST_IDLE;
      prim_r <= 1'b0;
      comp_r <= 1'b0;
    end else if (fall_ev) begin
      prim_r <= 1'b0;
      if (phf_r != cwg_pkg::CNT_RST) begin
        state_r <= cwg_pkg::ST_FPH;
        cnt_r <= phf_r;
      end else if (dbf_r != cwg_pkg::CNT_RST) begin
        state_r <= cwg_pkg::ST_FDB;
        cnt_r <= dbf_r;
      end else begin
        state_r <= cwg_pkg::ST_IDLE;
        comp_r <= 1'b1;
      end
    end else if (rise_ev) begin
      if (phr_r != cwg_pkg::CNT_RST) begin
        state_r <= cwg_pkg::ST_RPH;
        cnt_r <= phr_r;
      end else if (dbr_r != cwg_pkg::CNT_RST) begin
        comp_r <= 1'b0;
        state_r <= cwg_pkg::ST_RDB;
        cnt_r <= dbr_r;
      end else begin
        comp_r <= 1'b0;
        prim_r <= 1'b1;
        state_r <= cwg_pkg::ST_IDLE;
      end
    end else if (ref_tick && cnt_r != cwg_pkg::CNT_RST) begin
      cnt_r <= cnt_r - cwg_pkg::CNT_ONE;
      if (cnt_r == cwg_pkg::CNT_ONE) begin
        case (state_r)
          cwg_pkg::ST_RPH: begin
            comp_r <= 1'b0;
            if (dbr_r != cwg_pkg::CNT_RST) begin
              state_r <= cwg_pkg::ST_RDB;
              cnt_r <= dbr_r;
            end else begin
              prim_r <= 1'b1;
              state_r <= cwg_pkg::ST_IDLE;
            end
          end
          cwg_pkg::ST_FPH: begin
            if (dbf_r != cwg_pkg::CNT_RST) begin
              state_r <= cwg_pkg::ST_FDB;
              cnt_r <= dbf_r;
            end else begin
              comp_r <= 1'b1;
              state_r <= cwg_pkg::ST_IDLE;
            end
          end
          cwg_pkg::ST_RDB: begin
            prim_r <= 1'b1;
            state_r <= cwg_pkg::ST_IDLE;
          end
          cwg_pkg::ST_FDB: begin
            comp_r <= 1'b1;
            state_r <= cwg_pkg::ST_IDLE;
          end
          default: state_r <= cwg_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Push-pull pair select flips on every accepted rising event in push-pull mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_r <= 1'b1;
    end else if (rise_ev && ctrl_r.mode == cwg_pkg::MODE_PP) begin
      pair_r <= !pair_r;
    end
  end

  // ----------------------------------------------------------------
  // Output mapping, registered for clean pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_out_a <= 1'b0;
      drive_out_b <= 1'b0;
      drive_out_c <= 1'b0;
      drive_out_d <= 1'b0;
    end else if (ctrl_r.mode == cwg_pkg::MODE_HB) begin
      drive_out_a <= prim_r && steer_r.to_a;
      drive_out_c <= prim_r && steer_r.to_c;
      drive_out_b <= comp_r && steer_r.to_b;
      drive_out_d <= comp_r && steer_r.to_d;
    end else if (ctrl_r.mode == cwg_pkg::MODE_PP) begin
      drive_out_a <= prim_r && !pair_r;
      drive_out_c <= prim_r && !pair_r;
      drive_out_b <= prim_r && pair_r;
      drive_out_d <= prim_r && pair_r;
    end else begin
      drive_out_a <= 1'b0;
      drive_out_b <= 1'b0;
      drive_out_c <= 1'b0;
      drive_out_d <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read mux; unmapped addresses answer zero with an error
  always_comb begin
    map_hit = 1'b1;
    rd_nxt = 32'h0;
    case (paddr)
      cwg_pkg::OFF_CTRL: rd_nxt = {27'h0, ctrl_r};
      cwg_pkg::OFF_RIS: rd_nxt = {24'h0, ris_r};
      cwg_pkg::OFF_RSIM: rd_nxt = {24'h0, rsim_r};
      cwg_pkg::OFF_FIS: rd_nxt = {24'h0, fis_r};
      cwg_pkg::OFF_FSIM: rd_nxt = {24'h0, fsim_r};
      cwg_pkg::OFF_DBR: rd_nxt = {26'h0, dbr_r};
      cwg_pkg::OFF_DBF: rd_nxt = {26'h0, dbf_r};
      cwg_pkg::OFF_BLKR: rd_nxt = {26'h0, blkr_r};
      cwg_pkg::OFF_BLKF: rd_nxt = {26'h0, blkf_r};
      cwg_pkg::OFF_PHR: rd_nxt = {26'h0, phr_r};
      cwg_pkg::OFF_PHF: rd_nxt = {26'h0, phf_r};
      cwg_pkg::OFF_STEER: rd_nxt = {28'h0, steer_r};
      cwg_pkg::OFF_STAT: rd_nxt = {25'h0, pair_r, comp_r, prim_r,
                                   drive_out_d, drive_out_c, drive_out_b, drive_out_a};
      default: map_hit = 1'b0;
    endcase
  end

  // One wait state: answer lands on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !map_hit;
      prdata <= (acc && !pready && !pwrite) ? rd_nxt : 32'h0;
    end
  end

  // Register writes on the completing access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= cwg_pkg::CTRL_RST;
      steer_r <= cwg_pkg::STEER_RST;
      ris_r <= cwg_pkg::SRC_RST;
      rsim_r <= cwg_pkg::SRC_RST;
      fis_r <= cwg_pkg::SRC_RST;
      fsim_r <= cwg_pkg::SRC_RST;
      dbr_r <= cwg_pkg::CNT_RST;
      dbf_r <= cwg_pkg::CNT_RST;
      blkr_r <= cwg_pkg::CNT_RST;
      blkf_r <= cwg_pkg::CNT_RST;
      phr_r <= cwg_pkg::CNT_RST;
      phf_r <= cwg_pkg::CNT_RST;
    end else if (wr_en) begin
      case (paddr)
        cwg_pkg::OFF_CTRL: ctrl_r <= cwg_pkg::cwg_ctrl_t'(pwdata[4:0]);
        cwg_pkg::OFF_RIS: ris_r <= pwdata[7:0];
        cwg_pkg::OFF_RSIM: rsim_r <= pwdata[7:0];
        cwg_pkg::OFF_FIS: fis_r <= pwdata[7:0];
        cwg_pkg::OFF_FSIM: fsim_r <= pwdata[7:0];
        cwg_pkg::OFF_DBR: dbr_r <= pwdata[5:0];
        cwg_pkg::OFF_DBF: dbf_r <= pwdata[5:0];
        cwg_pkg::OFF_BLKR: blkr_r <= pwdata[5:0];
        cwg_pkg::OFF_BLKF: blkf_r <= pwdata[5:0];
        cwg_pkg::OFF_PHR: phr_r <= pwdata[5:0];
        cwg_pkg::OFF_PHF: phf_r <= pwdata[5:0];
        cwg_pkg::OFF_STEER: steer_r <= cwg_pkg::cwg_steer_t'(pwdata[3:0]);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  idle_mode_off_a: assert property (!active ##1 !active |=>
    !drive_out_a && !drive_out_b && !drive_out_c && !drive_out_d)
    else $error("outputs active outside a drive mode");
  pp_pairs_a: assert property ($past(ctrl_r.mode) == cwg_pkg::MODE_PP |->
    drive_out_a == drive_out_c && drive_out_b == drive_out_d && !(drive_out_a && drive_out_b))
    else $error("push-pull pair mismatch");
  pp_alternate_a: assert property (rise_ev && ctrl_r.mode == cwg_pkg::MODE_PP
    |=> pair_r != $past(pair_r))
    else $error("push-pull pair did not switch");
  no_overlap_a: assert property (!(prim_r && comp_r))
    else $error("primary and complementary overlap");
  fall_clears_a: assert property (fall_ev |=> !prim_r)
    else $error("primary not cleared by falling event");
  rise_at_once_a: assert property (rise_ev && !fall_ev && phr_r == 6'h00
    && dbr_r == 6'h00 |=> prim_r && !comp_r)
    else $error("primary not set at once");
  blank_holds_a: assert property (blank_fall_r != 6'h00 |-> !fall_ev)
    else $error("falling event taken while blanked");
  blank_load_a: assert property (rise_ev |=> blank_fall_r == $past(blkf_r))
    else $error("fall blanking not loaded on rising event");
  phase_wait_a: assert property (rise_ev && !fall_ev && phr_r != 6'h00 && !prim_r
    |=> !prim_r)
    else $error("drive started before phase delay");
  sysclk_tick_a: assert property (ctrl_r.cs == cwg_pkg::CS_FOSC |-> ref_tick)
    else $error("system clock select not ticking");
  hb_steer_a: assert property (ctrl_r.mode == cwg_pkg::MODE_HB
    |=> drive_out_a == $past(prim_r && steer_r.to_a))
    else $error("half-bridge steering wrong on A");
  apb_ready_a: assert property (acc && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle");

  hb_drive_c: cover property (ctrl_r.mode == cwg_pkg::MODE_HB && prim_r ##[1:200] comp_r);
  pp_switch_c: cover property (ctrl_r.mode == cwg_pkg::MODE_PP && drive_out_a
    ##[1:400] drive_out_b);
  phase_run_c: cover property (state_r == cwg_pkg::ST_RPH ##[1:200] state_r == cwg_pkg::ST_RDB);

endmodule

// *** tb/cwg_src_model.sv ***
// Periodic event source model standing in for an on-chip PWM
`timescale 1ns/1ns

module cwg_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [7:0] half,
  output logic pwm
);
  logic [7:0] cnt_r;

  // ----------------------------------------------------------------
  // Square wave
  // ----------------------------------------------------------------
  // Periodic source, so the bench selects edge sensing for it
  // Parks low when disabled so no stray event leaks into other tests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      pwm <= 1'b0;
    end else if (!en) begin
      cnt_r <= 8'h00;
      pwm <= 1'b0;
    end else if (cnt_r == half - 8'h01) begin
      cnt_r <= 8'h00;
      pwm <= !pwm;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule

// *** tb/tb_complementary_waveform_gen.sv ***
// Self-checking bench for the complementary waveform generator
`timescale 1ns/1ns

module tb_complementary_waveform_gen;
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] steer;
    logic [3:0] hi;
    logic [3:0] lo;
  } cwg_row_t;

  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, osc_tick, pm_en, pwm, rerr;
  logic [7:0] paddr, rs, fs;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pp_last, pp_prev;
  wire logic [3:0] outs;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int tc = 0;
  int pp_n = 0;
  bit pp_on = 0;
  int n0, n1, n2;
  cwg_row_t rows [7] = '{
    '{cwg_pkg::MODE_HB, 4'hF, 4'h5, 4'hA}, '{cwg_pkg::MODE_HB, 4'h1, 4'h1, 4'h0},
    '{cwg_pkg::MODE_HB, 4'h2, 4'h0, 4'h2}, '{cwg_pkg::MODE_HB, 4'h4, 4'h4, 4'h0},
    '{cwg_pkg::MODE_HB, 4'h8, 4'h0, 4'h8}, '{3'h0, 4'hF, 4'h0, 4'h0},
    '{3'h6, 4'hF, 4'h0, 4'h0}};

  cwg_top cwg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_tick(osc_tick), .rise_src(rs | {7'h00, pwm}),
    .fall_src(fs | {7'h00, pwm}), .drive_out_a(outs[0]), .drive_out_b(outs[1]),
    .drive_out_c(outs[2]), .drive_out_d(outs[3]));
  cwg_src_model cwg_src_model_i (.pclk(pclk), .presetn(presetn), .en(pm_en),
    .half(8'h0A), .pwm(pwm));

  // ----------------------------------------------------------------
  // Clock, oscillator tick and timeout
  // ----------------------------------------------------------------
  always #5 pclk = !pclk;
  // Tick every 12 pclk, close enough to the slow oscillator for ordering checks
  always @(posedge pclk) begin
    osc_tick <= (tc == 0);
    tc <= (tc == 11) ? 0 : tc + 1;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // Push-pull: each new drive period must use the other pair, A=C and B=D
  always @(posedge pclk) begin
    if (pp_on && outs !== 4'h0 && pp_prev === 4'h0) begin
      chk(outs, (pp_last == 4'h5) ? 4'hA : 4'h5);
      pp_last <= outs;
      pp_n++;
    end
    pp_prev <= outs;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ok(input bit c);
    tests_run++;
    if (!c) begin
      failures++;
      $display("[ERR] %0t timing out of range", $time);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk_ok(n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never re-raises psel in this time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  task automatic cfg(input logic [1:0] cs, input logic [2:0] m, input logic [3:0] st);
    wr(cwg_pkg::OFF_CTRL, {27'h0, cs, m});
    wr(cwg_pkg::OFF_STEER, {28'h0, st});
  endtask

  task automatic src(input logic v, input int k);
    rs[0] <= v;
    fs[0] <= v;
    repeat (k) @(posedge pclk);
  endtask

  // Cycles until output i shows v, bounded
  task automatic wt(input int i, input logic v, output int n);
    n = 0;
    while (outs[i] !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic rst;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(cwg_pkg::OFF_RIS, 32'h1);
    wr(cwg_pkg::OFF_RSIM, 32'h1);
    wr(cwg_pkg::OFF_FIS, 32'h1);
    wr(cwg_pkg::OFF_FSIM, 32'h1);
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, osc_tick, pm_en} = 6'h00;
    {paddr, rs, fs, pwdata} = 56'h0;
    {pp_last, pp_prev} = 8'hA0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(outs, 4'h0);
    rd_chk(cwg_pkg::OFF_CTRL, 32'h0);
    rd_chk(cwg_pkg::OFF_STEER, 32'hF);
    rd_chk(cwg_pkg::OFF_RIS, 32'h0);
    apb(1'b0, 8'h34, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    wr(cwg_pkg::OFF_DBR, 32'hFF);
    rd_chk(cwg_pkg::OFF_DBR, 32'h3F);
    wr(cwg_pkg::OFF_DBR, 32'h0);
    rst();
    // Mode, steering and complement per row, source edges at both ends
    foreach (rows[i]) begin
      cfg(cwg_pkg::CS_FOSC, rows[i].mode, rows[i].steer);
      src(1'b1, 8);
      chk(outs, rows[i].hi);
      src(1'b0, 8);
      chk(outs, rows[i].lo);
    end
    // Dead-band: gap between one output off and the other on
    cfg(cwg_pkg::CS_FOSC, cwg_pkg::MODE_HB, 4'hF);
    wr(cwg_pkg::OFF_DBR, 32'h3);
    wr(cwg_pkg::OFF_DBF, 32'h2);
    // Complementary high first, so both ends of the rising gap are seen
    src(1'b1, 16);
    src(1'b0, 16);
    src(1'b1, 0);
    wt(1, 1'b0, n0);
    wt(0, 1'b1, n1);
    chk(n1, 3);
    src(1'b0, 0);
    wt(0, 1'b0, n0);
    wt(1, 1'b1, n1);
    chk(n1, 2);
    wr(cwg_pkg::OFF_DBR, 32'h0);
    wr(cwg_pkg::OFF_DBF, 32'h0);
    // Phase delay adds its count of reference ticks
    src(1'b1, 0);
    wt(0, 1'b1, n0);
    src(1'b0, 8);
    wr(cwg_pkg::OFF_PHR, 32'h4);
    src(1'b1, 0);
    wt(0, 1'b1, n1);
    chk(n1 - n0, 4);
    src(1'b0, 8);
    wr(cwg_pkg::OFF_PHR, 32'h0);
    // Falling input blanked right after the rising drive
    wr(cwg_pkg::OFF_BLKF, 32'h8);
    src(1'b1, 0);
    wt(0, 1'b1, n0);
    src(1'b0, 8);
    chk(outs, 4'h5);
    src(1'b1, 16);
    src(1'b0, 8);
    chk(outs, 4'hA);
    wr(cwg_pkg::OFF_BLKF, 32'h0);
    // Each clock select code: latency grows with slower reference
    for (int c = 3; c >= 0; c--) begin
      cfg(c[1:0], cwg_pkg::MODE_HB, 4'hF);
      src(1'b1, 0);
      wt(0, 1'b1, n2);
      if (c == 3) chk(n2, 100);
      else if (c == 2) chk_ok(n2 <= 5);
      else if (c == 1) chk_ok(n2 > 5 && n2 <= 14);
      else chk_ok(n2 > 12 && n2 <= 45);
      cfg(cwg_pkg::CS_FOSC, cwg_pkg::MODE_HB, 4'hF);
      src(1'b0, 8);
    end
    // Events are the OR of enabled sources only; level fall source 1 parked high
    fs <= 8'h02;
    wr(cwg_pkg::OFF_RIS, 32'h6);
    wr(cwg_pkg::OFF_RSIM, 32'h0);
    wr(cwg_pkg::OFF_FIS, 32'h6);
    wr(cwg_pkg::OFF_FSIM, 32'h4);
    rs <= 8'h01;
    repeat (8) @(posedge pclk);
    chk(outs, 4'hA);
    rs <= 8'h02;
    repeat (8) @(posedge pclk);
    chk(outs, 4'h5);
    rs <= 8'h00;
    fs <= 8'h06;
    repeat (4) @(posedge pclk);
    fs <= 8'h02;
    repeat (8) @(posedge pclk);
    chk(outs, 4'hA);
    rs <= 8'h02;
    repeat (8) @(posedge pclk);
    chk(outs, 4'h5);
    rs <= 8'h00;
    fs <= 8'h00;
    repeat (8) @(posedge pclk);
    chk(outs, 4'hA);
    rd_chk(cwg_pkg::OFF_STAT, 32'h6A);
    // Reset in mid-run clears drive and the push-pull pair
    rst();
    chk(outs, 4'h0);
    cfg(cwg_pkg::CS_FOSC, cwg_pkg::MODE_PP, 4'hF);
    pp_on = 1;
    pm_en <= 1'b1;
    repeat (130) @(posedge pclk);
    pm_en <= 1'b0;
    repeat (20) @(posedge pclk);
    pp_on = 0;
    chk_ok(pp_n >= 5);
    chk(outs, 4'h0);
    finish_test();
  end
endmodule
